// ===== src/wkc_cfg.svh
// Offsets, field positions, reset values and counts of the wakeup/config bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WKC_CFG_SVH
`define WKC_CFG_SVH

// Register indices; byte address is four times the index
`define WKC_IDX_PORT_A     8'h00
`define WKC_IDX_KEY_SC     8'h01
`define WKC_IDX_KEY_IE     8'h02
`define WKC_IDX_CFG_TWO    8'h1e
`define WKC_IDX_CFG_ONE    8'h1f

// Port A data fields
`define WKC_PA_WAKE_BIT    6

// Key status control fields
`define WKC_KS_PEND_BIT    3
`define WKC_KS_ACK_BIT     2
`define WKC_KS_MASK_BIT    1

// Key interrupt enable fields
`define WKC_KE_WAKE_BIT    6

// Config two fields
`define WKC_C2_PUOFF_BIT   7
`define WKC_C2_IRQ_PIN_EN_BIT   6
`define WKC_C2_OSC_BIT     1
`define WKC_C2_RESET_PIN_EN_BIT   0

// Config one fields
`define WKC_C1_PSEL_BIT    7
`define WKC_C1_LSTOP_BIT   6
`define WKC_C1_LROFF_BIT   5
`define WKC_C1_LPOFF_BIT   4
`define WKC_C1_TRIP_BIT    3
`define WKC_C1_SHORT_STOP_RECOVERY_BIT   2

// Reset values
`define WKC_CFG_ONE_RST    8'h00
`define WKC_CFG_TWO_RST    8'h00

// Cycle counts
`define WKC_WAKE_SHORT     512
`define WKC_WAKE_LONG      16384
`define WKC_WDOG_SHORT     8176
`define WKC_WDOG_LONG      262128
`define WKC_REC_SHORT      32
`define WKC_REC_LONG       4096

`endif

// ===== src/wkc_pkg.sv
// Types shared by the wakeup/config register bank.
// Assumes wkc_cfg.svh is on the include path.
`include "wkc_cfg.svh"

package wkc_pkg;

  // Wakeup counter states
  typedef enum logic [1:0] {
    WKC_IDLE = 2'b01,
    WKC_RUN  = 2'b10
  } wkc_tmr_e;

  // Option outputs toward the rest of the chip
  typedef struct packed {
    logic        osc_keep_in_stop;
    logic        main_osc_off;
    logic        lvi_monitor_on;
    logic        lvi_reset_en;
    logic        lvi_5v_sel;
    logic        irq_pullup_en;
    logic        irq_pin_func;
    logic        reset_pin_func;
    logic [17:0] wdog_cycles;
    logic [12:0] recovery_cycles;
  } wkc_opts_s;

endpackage

// ===== src/wkc_wake_timer.sv
// Wakeup period generator counting ticks of the selected wakeup clock.
// Assumes tick inputs are one-cycle enables synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
`include "wkc_cfg.svh"

module wkc_wake_timer
  import wkc_pkg::*;
#(
  parameter int WAKE_LONG = `WKC_WAKE_LONG
) (
  // Clock, reset, enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Control
  input  wire logic stop_mode,
  input  wire logic period_short,
  input  wire logic tick,
  // Result
  output logic      overflow
);

  typedef struct packed {
    wkc_tmr_e    st;
    logic [14:0] cnt;
    logic        ovf;
  } wkc_tmr_s;

  wkc_tmr_s st_q;
  wkc_tmr_s next_st;
  logic [14:0] limit;

  // Terminal count for the selected period
  assign limit = period_short ? 15'(`WKC_WAKE_SHORT - 1)
                              : 15'(WAKE_LONG - 1);
  assign overflow = st_q.ovf;

  // Counter idle out of stop, restarted at entry
  always_comb begin
    next_st = st_q;
    next_st.ovf = 1'b0;
    case (st_q.st)
      WKC_IDLE: begin
        next_st.cnt = 15'h0000;
        if (stop_mode) begin
          next_st.st = WKC_RUN;
        end
      end
      WKC_RUN: begin
        if (!stop_mode) begin
          next_st.st  = WKC_IDLE;
          next_st.cnt = 15'h0000;
        end else if (tick) begin
          if (st_q.cnt >= limit) begin
            next_st.cnt = 15'h0000;
            next_st.ovf = 1'b1;
          end else begin
            next_st.cnt = st_q.cnt + 15'h0001;
          end
        end
      end
      default: begin
        next_st.st  = WKC_IDLE;
        next_st.cnt = 15'h0000;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{st: WKC_IDLE, cnt: 15'h0000, ovf: 1'b0};
    end else if (ce) begin
      st_q <= next_st;
    end
  end

  // Counter never runs outside stop
  chk_idle_out_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !stop_mode) |=> (st_q.cnt == 15'h0000) && !st_q.ovf)
    else $error("wakeup counter active outside stop");

endmodule
`default_nettype wire

// ===== src/wkc_regs.sv
// APB register bank for stop-mode wakeup, key status and option registers.
// Assumes pins and ticks synchronous to pclk; por_n is the power-on reset.
`timescale 1ns/1ns
`default_nettype none
`include "wkc_cfg.svh"

module wkc_regs
  import wkc_pkg::*;
#(
  parameter int WAKE_LONG = `WKC_WAKE_LONG,
  parameter int WDOG_LONG = `WKC_WDOG_LONG
) (
  // Clock, resets, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip status
  input  wire logic        stop_mode,
  input  wire logic        lvi_stop_exit,
  input  wire logic [5:0]  port_a_pins,
  input  wire logic        key_pin_req,
  input  wire logic        wake_rc_osc,
  input  wire logic        bus_clk_x2_a,
  // Interrupt and wakeup
  output logic             key_irq,
  output logic             stop_wakeup,
  // Options
  output wkc_opts_s        opts
);

  // Main state
  typedef struct packed {
    logic        wake_latch;
    logic        kbd_latch;
    logic        key_irq_mask;
    logic        wake_irq_en;
    logic        irq_pullup_off;
    logic        irq_pin_en;
    logic        osc_run_in_stop;
    logic [7:0]  config_one;
    logic        one_done;
    logic        two_done;
    logic [31:0] rdata;
  } wkc_state_s;

  // Bits kept across all but power-on reset
  typedef struct packed {
    logic reset_pin_en;
    logic lvi_trip_sel;
  } wkc_por_s;

  wkc_state_s st_q;
  wkc_state_s next_st;
  wkc_por_s   por_q;
  wkc_por_s   next_por;

  logic [7:0] idx;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic       wake_tick;
  logic       wake_ovf;
  logic       pending;

  // Address index decode
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `WKC_IDX_PORT_A) || (i == `WKC_IDX_KEY_SC) ||
                (i == `WKC_IDX_KEY_IE) || (i == `WKC_IDX_CFG_TWO) ||
                (i == `WKC_IDX_CFG_ONE);
  endfunction

  // Bus decode
  assign idx     = paddr[9:2];
  assign mapped  = is_mapped(idx) && (paddr[1:0] == 2'b00);
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite && ce && mapped;
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st_q.rdata;

  // Wakeup clock selection
  assign wake_tick = st_q.osc_run_in_stop ? bus_clk_x2_a : wake_rc_osc;

  wkc_wake_timer #(
    .WAKE_LONG (WAKE_LONG)
  ) u_timer (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .stop_mode    (stop_mode),
    .period_short (st_q.config_one[`WKC_C1_PSEL_BIT]),
    .tick         (wake_tick),
    .overflow     (wake_ovf)
  );

  // Shared interrupt and stop wakeup
  assign pending     = st_q.wake_latch || st_q.kbd_latch;
  assign key_irq     = pending && !st_q.key_irq_mask;
  assign stop_wakeup = key_irq && stop_mode;

  // Read data mux, sampled in the setup cycle
  function automatic logic [31:0] read_word(input logic [7:0] i,
                                            input wkc_state_s s,
                                            input wkc_por_s p,
                                            input logic [5:0] pins,
                                            input logic pend);
    read_word = 32'h0000_0000;
    case (i)
      `WKC_IDX_PORT_A: begin
        read_word[5:0] = pins;
        read_word[`WKC_PA_WAKE_BIT] = s.wake_latch;
      end
      `WKC_IDX_KEY_SC: begin
        // Upper nibble and ack read as zero
        read_word[`WKC_KS_PEND_BIT] = pend;
        read_word[`WKC_KS_MASK_BIT] = s.key_irq_mask;
      end
      `WKC_IDX_KEY_IE: begin
        read_word[`WKC_KE_WAKE_BIT] = s.wake_irq_en;
      end
      `WKC_IDX_CFG_TWO: begin
        read_word[`WKC_C2_PUOFF_BIT] = s.irq_pullup_off;
        read_word[`WKC_C2_IRQ_PIN_EN_BIT] = s.irq_pin_en;
        read_word[`WKC_C2_OSC_BIT]   = s.osc_run_in_stop;
        read_word[`WKC_C2_RESET_PIN_EN_BIT] = p.reset_pin_en;
      end
      `WKC_IDX_CFG_ONE: begin
        read_word[7:0] = s.config_one;
        read_word[`WKC_C1_TRIP_BIT] = p.lvi_trip_sel;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  endfunction

  // Next state of registers and latches
  always_comb begin
    next_st  = st_q;
    next_por = por_q;
    if (setup && !pwrite) begin
      // Unmapped or misaligned reads return zero
      next_st.rdata = mapped ? read_word(idx, st_q, por_q, port_a_pins,
                                         pending) : 32'h0000_0000;
    end
    // Ack clears both latches; a new event in the same cycle wins
    if (wr && idx == `WKC_IDX_KEY_SC) begin
      next_st.key_irq_mask = pwdata[`WKC_KS_MASK_BIT];
      if (pwdata[`WKC_KS_ACK_BIT]) begin
        next_st.wake_latch = 1'b0;
        next_st.kbd_latch  = 1'b0;
      end
    end
    if (wr && idx == `WKC_IDX_KEY_IE) begin
      next_st.wake_irq_en = pwdata[`WKC_KE_WAKE_BIT];
    end
    if (wr && idx == `WKC_IDX_CFG_TWO && !st_q.two_done) begin
      next_st.two_done        = 1'b1;
      next_st.irq_pullup_off  = pwdata[`WKC_C2_PUOFF_BIT];
      next_st.irq_pin_en      = pwdata[`WKC_C2_IRQ_PIN_EN_BIT];
      next_st.osc_run_in_stop = pwdata[`WKC_C2_OSC_BIT];
      next_por.reset_pin_en   = pwdata[`WKC_C2_RESET_PIN_EN_BIT];
    end
    if (wr && idx == `WKC_IDX_CFG_ONE && !st_q.one_done) begin
      next_st.one_done      = 1'b1;
      next_st.config_one    = pwdata[7:0];
      next_por.lvi_trip_sel = pwdata[`WKC_C1_TRIP_BIT];
    end
    if (wake_ovf && st_q.wake_irq_en) begin
      next_st.wake_latch = 1'b1;
    end
    if (key_pin_req) begin
      next_st.kbd_latch = 1'b1;
    end
  end

  // Registers cleared by presetn only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{
        wake_latch:      1'b0,
        kbd_latch:       1'b0,
        key_irq_mask:    1'b0,
        wake_irq_en:     1'b0,
        irq_pullup_off:  1'b0,
        irq_pin_en:      1'b0,
        osc_run_in_stop: 1'b0,
        config_one:      `WKC_CFG_ONE_RST,
        one_done:        1'b0,
        two_done:        1'b0,
        rdata:           32'h0000_0000
      };
    end else if (ce) begin
      st_q <= next_st;
    end
  end

  // Registers cleared by power-on reset only
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      por_q <= '{reset_pin_en: 1'b0, lvi_trip_sel: 1'b0};
    end else if (ce) begin
      por_q <= next_por;
    end
  end

  // Option outputs
  always_comb begin
    opts = '0;
    opts.osc_keep_in_stop = st_q.osc_run_in_stop;
    opts.main_osc_off     = stop_mode && !st_q.osc_run_in_stop;
    opts.lvi_monitor_on   = !st_q.config_one[`WKC_C1_LPOFF_BIT] &&
                            (!stop_mode ||
                             st_q.config_one[`WKC_C1_LSTOP_BIT]);
    opts.lvi_reset_en     = opts.lvi_monitor_on &&
                            !st_q.config_one[`WKC_C1_LROFF_BIT];
    opts.lvi_5v_sel       = por_q.lvi_trip_sel;
    opts.irq_pullup_en    = !st_q.irq_pullup_off;
    opts.irq_pin_func     = st_q.irq_pin_en;
    opts.reset_pin_func   = por_q.reset_pin_en;
    opts.wdog_cycles      = st_q.config_one[`WKC_C1_PSEL_BIT] ?
                            18'(`WKC_WDOG_SHORT) : 18'(WDOG_LONG);
    opts.recovery_cycles  = (st_q.config_one[`WKC_C1_SHORT_STOP_RECOVERY_BIT] &&
                             !lvi_stop_exit) ?
                            13'(`WKC_REC_SHORT) :
                            13'(`WKC_REC_LONG);
  end

  // Ack in the same write clears pending unless a new event arrives
  chk_ack_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `WKC_IDX_KEY_SC && pwdata[`WKC_KS_ACK_BIT] &&
     !key_pin_req && !wake_ovf) |=> !pending)
    else $error("key ack did not clear pending request");

  // Key status upper nibble and ack read zero
  chk_ksc_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && setup && !pwrite && idx == `WKC_IDX_KEY_SC) |=>
      (prdata[7:4] == 4'h0) && !prdata[`WKC_KS_ACK_BIT])
    else $error("key status reserved or ack bit read nonzero");

  // Overflow with enable sets the latch
  chk_ovf_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && wake_ovf && st_q.wake_irq_en) |=> st_q.wake_latch)
    else $error("overflow did not set wake latch");

  // No latching while enable is clear
  chk_no_latch_dis: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !st_q.wake_latch && !st_q.wake_irq_en) |=> !st_q.wake_latch)
    else $error("wake latch set while disabled");

  // Interrupt gated by mask
  chk_mask_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.key_irq_mask |-> !key_irq && !stop_wakeup)
    else $error("masked request raised interrupt");

  // Second config write ignored
  chk_cfg_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.one_done && wr && idx == `WKC_IDX_CFG_ONE) |=>
      $stable(st_q.config_one))
    else $error("config one changed after first write");

  // Long recovery after low-voltage exit
  chk_lvi_long_rec: assert property (
    @(posedge pclk) disable iff (!presetn)
    lvi_stop_exit |-> opts.recovery_cycles == 13'(`WKC_REC_LONG))
    else $error("short recovery after low-voltage exit");

  // Main oscillator off in stop without keep option
  chk_osc_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stop_mode && !st_q.osc_run_in_stop) |-> opts.main_osc_off)
    else $error("main oscillator left running in stop");

  // Read of port A returns the latch at bit 6
  chk_pa_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && setup && !pwrite && mapped && idx == `WKC_IDX_PORT_A) |=>
      prdata[`WKC_PA_WAKE_BIT] == $past(st_q.wake_latch))
    else $error("port A bit 6 does not show wake latch");

endmodule
`default_nettype wire

// ===== sim/tb_wakeup_and_config_regs.sv
// Self-checking bench for the wakeup, key status and option register bank.
// Assumes wkc_pkg, wkc_wake_timer and wkc_regs compile ahead of this file.
`timescale 1ns/1ns
`default_nettype none
`include "wkc_cfg.svh"

module tb_wakeup_and_config_regs
  import wkc_pkg::*;
;
  localparam int WAKE_L = 64;
  localparam int WDOG_L = 8192;

  // Stimulus and observed outputs
  logic        pclk;
  logic        presetn;
  logic        por_n;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stop_mode;
  logic        lvi_stop_exit;
  logic [5:0]  port_a_pins;
  logic        key_pin_req;
  logic        wake_rc_osc;
  logic        bus_clk_x2_a;
  logic        key_irq;
  logic        stop_wakeup;
  wkc_opts_s   opts;
  int          failures;
  int          num_checks;

  wkc_regs #(.WAKE_LONG(WAKE_L), .WDOG_LONG(WDOG_L)) u_dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode),
    .lvi_stop_exit(lvi_stop_exit), .port_a_pins(port_a_pins),
    .key_pin_req(key_pin_req), .wake_rc_osc(wake_rc_osc),
    .bus_clk_x2_a(bus_clk_x2_a), .key_irq(key_irq),
    .stop_wakeup(stop_wakeup), .opts(opts)
  );

  // 250 MHz clock
  always #2 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] addr,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {idx, 2'b00}, 8'h00, r, e);
    chk(what, exp, r);
  endtask

  task automatic settle();
    @(negedge pclk);
  endtask

  // Wait out the latch pipeline, then compare irq and wakeup
  task automatic irq_is(input string what, input logic [31:0] exp);
    repeat (3) @(posedge pclk);
    settle();
    chk(what, exp, {30'h0, key_irq, stop_wakeup});
  endtask

  // Single-bit option outputs, in struct order
  function automatic logic [31:0] obits();
    return {24'h0, opts.osc_keep_in_stop, opts.main_osc_off,
            opts.lvi_monitor_on, opts.lvi_reset_en, opts.lvi_5v_sel,
            opts.irq_pullup_en, opts.irq_pin_func, opts.reset_pin_func};
  endfunction

  task automatic do_reset(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask

  // Hold the chosen tick high for n cycles
  task automatic ticks(input logic bus, input int n);
    @(posedge pclk);
    if (bus) bus_clk_x2_a <= 1'b1;
    else wake_rc_osc <= 1'b1;
    repeat (n) @(posedge pclk);
    bus_clk_x2_a <= 1'b0;
    wake_rc_osc <= 1'b0;
  endtask

  task automatic set_stop(input logic s);
    @(posedge pclk);
    stop_mode <= s;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_map();
    logic [31:0] r;
    logic        e;
    rd_chk("port a", `WKC_IDX_PORT_A, 32'h2a);
    rd_chk("key sc", `WKC_IDX_KEY_SC, 32'h00);
    rd_chk("key ie", `WKC_IDX_KEY_IE, 32'h00);
    rd_chk("cfg two", `WKC_IDX_CFG_TWO, 32'h00);
    rd_chk("cfg one", `WKC_IDX_CFG_ONE, 32'h00);
    apb(1'b1, {8'h03, 2'b00}, 8'hff, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, {`WKC_IDX_PORT_A, 2'b10}, 8'h00, r, e);
    chk("misaligned err", 32'h1, {31'h0, e});
    chk("misaligned data", 32'h0, r);
    $display("test map finished");
  endtask

  task automatic t_key();
    @(posedge pclk);
    key_pin_req <= 1'b1;
    @(posedge pclk);
    key_pin_req <= 1'b0;
    irq_is("key irq", 32'h2);
    rd_chk("key pend", `WKC_IDX_KEY_SC, 32'h08);
    wr(`WKC_IDX_KEY_SC, 8'h02);
    irq_is("key masked", 32'h0);
    rd_chk("key mask", `WKC_IDX_KEY_SC, 32'h0a);
    wr(`WKC_IDX_KEY_SC, 8'h04);
    irq_is("key acked", 32'h0);
    rd_chk("key sc ack", `WKC_IDX_KEY_SC, 32'h00);
    $display("test key finished");
  endtask

  // Clock enable low freezes latches and stalls the bus
  task automatic t_ce();
    @(posedge pclk);
    ce <= 1'b0;
    key_pin_req <= 1'b1;
    @(posedge pclk);
    key_pin_req <= 1'b0;
    settle();
    chk("pready stalled", 32'h0, {31'h0, pready});
    @(posedge pclk);
    ce <= 1'b1;
    irq_is("ce frozen", 32'h0);
    rd_chk("ce key sc", `WKC_IDX_KEY_SC, 32'h00);
    $display("test enable finished");
  endtask

  task automatic t_opts_first();
    wr(`WKC_IDX_CFG_TWO, 8'hc3);
    wr(`WKC_IDX_CFG_ONE, 8'hcc);
    set_stop(1'b1);
    chk("opt bits", 32'hbb, obits());
    chk("wdog", 32'h1ff0, {14'h0, opts.wdog_cycles});
    chk("recov", 32'h20, {19'h0, opts.recovery_cycles});
    lvi_stop_exit <= 1'b1;
    settle();
    chk("recov lvi", 32'h1000, {19'h0, opts.recovery_cycles});
    @(posedge pclk);
    lvi_stop_exit <= 1'b0;
    set_stop(1'b0);
    wr(`WKC_IDX_CFG_ONE, 8'h30);
    wr(`WKC_IDX_CFG_TWO, 8'h00);
    rd_chk("cfg one once", `WKC_IDX_CFG_ONE, 32'hcc);
    rd_chk("cfg two once", `WKC_IDX_CFG_TWO, 32'hc3);
    $display("test options first finished");
  endtask

  task automatic t_opts_second();
    rd_chk("cfg two kept", `WKC_IDX_CFG_TWO, 32'h01);
    rd_chk("cfg one kept", `WKC_IDX_CFG_ONE, 32'h08);
    set_stop(1'b1);
    chk("opt bits", 32'h4d, obits());
    chk("wdog", WDOG_L, {14'h0, opts.wdog_cycles});
    chk("recov", 32'h1000, {19'h0, opts.recovery_cycles});
    set_stop(1'b0);
    wr(`WKC_IDX_CFG_ONE, 8'h38);
    settle();
    chk("opt bits off", 32'h0d, obits());
    $display("test options second finished");
  endtask

  // Wake timer: enable, source, idle outside stop, restart, ack
  task automatic t_wake(input logic bus, input int n);
    wr(`WKC_IDX_KEY_IE, 8'h00);
    set_stop(1'b1);
    ticks(bus, n + 2);
    irq_is("wake disabled", 32'h0);
    set_stop(1'b0);
    wr(`WKC_IDX_KEY_IE, 8'h40);
    rd_chk("key ie", `WKC_IDX_KEY_IE, 32'h40);
    ticks(bus, n);
    set_stop(1'b1);
    ticks(!bus, n);
    ticks(bus, n - 1);
    irq_is("wake early", 32'h0);
    set_stop(1'b0);
    set_stop(1'b1);
    ticks(bus, n - 1);
    irq_is("wake restart", 32'h0);
    ticks(bus, 1);
    irq_is("wake irq", 32'h3);
    rd_chk("port a latch", `WKC_IDX_PORT_A, 32'h6a);
    rd_chk("key sc latch", `WKC_IDX_KEY_SC, 32'h08);
    wr(`WKC_IDX_KEY_SC, 8'h04);
    irq_is("wake acked", 32'h0);
    rd_chk("port a ack", `WKC_IDX_PORT_A, 32'h2a);
    set_stop(1'b0);
    $display("test wake finished");
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    por_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    lvi_stop_exit = 1'b0;
    port_a_pins = 6'h2a;
    key_pin_req = 1'b0;
    wake_rc_osc = 1'b0;
    bus_clk_x2_a = 1'b0;
    failures = 0;
    num_checks = 0;
    do_reset(1'b1);
    t_map();
    t_key();
    t_ce();
    t_opts_first();
    t_wake(1'b1, `WKC_WAKE_SHORT);
    do_reset(1'b0);
    t_opts_second();
    t_wake(1'b0, WAKE_L);
    do_reset(1'b1);
    rd_chk("cfg two por", `WKC_IDX_CFG_TWO, 32'h00);
    rd_chk("cfg one por", `WKC_IDX_CFG_ONE, 32'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
